// *** hw/clock_output_gating_regs.v ***
// serial block-write target holding the clock output gating control bytes
`timescale 1ns/1ps
`include "clock_gating_defines.vh"

module clock_output_gating_regs #(
  parameter [3:0] REVISION_CODE = 4'h3, // arbitrary value
  parameter [3:0] VENDOR_CODE = 4'h5 // arbitrary value
) (
  input wire sys_clk,
  input wire resetn,
  input wire scl,
  input wire sda,
  output reg sda_oe,
  input wire current_multiplier_select,
  output wire [7:0] cpu_pair_control,
  output wire [7:0] bus_clock_enables,
  output wire [7:0] fixed48_and_freerun_control,
  output wire [7:0] medium_clock_enables,
  output wire [7:0] delay_edge_tuning,
  output wire [7:0] maker_revision_ident
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // bit 0 serial clock, bit 1 serial data, bit 2 multiplier select
  localparam [2:0] PIN_IDLE = 3'b011; // bus lines idle high through the pull-up

  wire [2:0] pin_raw = {current_multiplier_select, sda, scl};
  wire [2:0] pin_lvl;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_sync
      reg [2:0] sync_reg;
      reg lvl_reg;

      // three stages; a level counts once stages two and three agree
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          sync_reg <= {3{PIN_IDLE[g]}};
          lvl_reg <= PIN_IDLE[g];
        end else begin
          sync_reg <= {sync_reg[1:0], pin_raw[g]};
          if (sync_reg[1] == sync_reg[2])
            lvl_reg <= sync_reg[2];
        end
      end

      assign pin_lvl[g] = lvl_reg;
    end
  endgenerate

  wire scl_lvl = pin_lvl[0];
  wire sda_lvl = pin_lvl[1];
  wire mult_lvl = pin_lvl[2];

  // ------------------------------------------------------------
  // bus condition detection
  // ------------------------------------------------------------
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise = scl_lvl & ~scl_d_reg;
  wire scl_fall = ~scl_lvl & scl_d_reg;
  wire start_cond = scl_lvl & scl_d_reg & sda_d_reg & ~sda_lvl;
  wire stop_cond = scl_lvl & scl_d_reg & ~sda_d_reg & sda_lvl;

  // delayed copies; idle high so no false edge follows reset
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_lvl;
      sda_d_reg <= sda_lvl;
    end
  end

  // ------------------------------------------------------------
  // protocol state machine
  // ------------------------------------------------------------
  // transfer phases
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_CMD = 3'h2;
  localparam [2:0] ST_COUNT = 3'h3;
  localparam [2:0] ST_DATA = 3'h4;
  localparam [2:0] ST_IGNORE = 3'h5;
  localparam [2:0] IDX_LAST = 3'h7; // byte index saturates here

  // transfer tracking
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg ack_phase_reg;
  reg ack_ok_reg;
  reg [7:0] remain_reg;
  reg [2:0] index_reg;

  // writable control bytes
  reg [7:0] cpu_reg;
  reg [7:0] bus_reg;
  reg [7:0] f48_reg;
  reg [7:0] med_reg;
  reg [7:0] tune_reg;

  // byte assembly, msb first
  wire [7:0] byte_in = {shift_reg[6:0], sda_lvl};
  wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);

  // decision taken on the eighth bit of each byte
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_ADDR: state_next = (byte_in == `SLAVE_ADDR_W) ? ST_CMD : ST_IGNORE;
      ST_CMD: state_next = (byte_in == `CMD_BLOCK) ? ST_COUNT : ST_IGNORE;
      ST_COUNT: state_next = (byte_in >= `COUNT_MIN && byte_in <= `COUNT_MAX) ?
                             ST_DATA : ST_IGNORE;
      ST_DATA: state_next = (remain_reg == 8'h01) ? ST_IGNORE : ST_DATA;
      ST_IDLE: state_next = ST_IDLE;
      ST_IGNORE: state_next = ST_IGNORE;
      default: state_next = ST_IDLE;
    endcase
  end

  // masked write of one control byte; read-only bits keep zero
  function [7:0] merge;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = data & mask;
    end
  endfunction

  // bit shifting, byte sequencing and register writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      remain_reg <= 8'h00;
      index_reg <= 3'h0;
      cpu_reg <= `RST_CPU;
      bus_reg <= `RST_BUS;
      f48_reg <= `RST_F48;
      med_reg <= `RST_MED;
      tune_reg <= `RST_TUNE;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
    end else begin
      // eighth rise: keep the byte, decide the acknowledge, step the phase
      if (byte_done) begin
        ack_phase_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
        shift_reg <= byte_in;
        ack_ok_reg <= (state_reg != ST_IDLE) && (state_reg != ST_IGNORE) &&
                      (state_next != ST_IGNORE || state_reg == ST_DATA);
        state_reg <= state_next;
        if (state_reg == ST_COUNT) begin
          remain_reg <= byte_in;
          index_reg <= 3'h0;
        end
        if (state_reg == ST_DATA) begin
          remain_reg <= remain_reg - 8'h01;
          index_reg <= (index_reg == IDX_LAST) ? index_reg : index_reg + 3'h1;
          case (index_reg)
            `IDX_CPU: cpu_reg <= merge(byte_in, `MASK_CPU);
            `IDX_BUS: bus_reg <= merge(byte_in, `MASK_BUS);
            `IDX_F48: f48_reg <= merge(byte_in, `MASK_F48);
            `IDX_MED: med_reg <= merge(byte_in, `MASK_MED);
            `IDX_TUNE: tune_reg <= merge(byte_in, `MASK_TUNE);
            default: tune_reg <= tune_reg;
          endcase
        end
      end else if (scl_rise && !ack_phase_reg) begin
        shift_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_rise && ack_phase_reg) begin
        ack_phase_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // acknowledge driver
  // ------------------------------------------------------------
  // pull data low from the eighth fall to the ninth; start and stop release it
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      sda_oe <= 1'b0;
    else if (start_cond || stop_cond)
      sda_oe <= 1'b0;
    else if (scl_fall)
      sda_oe <= ack_phase_reg & ack_ok_reg;
  end

  // ------------------------------------------------------------
  // control byte outputs
  // ------------------------------------------------------------
  reg [7:0] ident_reg;

  // identity byte from the revision and vendor codes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      ident_reg <= 8'h00;
    else
      ident_reg <= {REVISION_CODE, VENDOR_CODE};
  end

  // control bytes straight from their flip-flops; byte1 bit 7 is the live select
  assign cpu_pair_control = {mult_lvl, cpu_reg[6:0]};
  assign bus_clock_enables = bus_reg;
  assign fixed48_and_freerun_control = f48_reg;
  assign medium_clock_enables = med_reg;
  assign delay_edge_tuning = tune_reg;
  assign maker_revision_ident = ident_reg;

endmodule

// *** pkg/clock_gating_defines.vh ***
// constants for the clock output gating control bytes and serial target
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef CLOCK_GATING_DEFINES_VH
`define CLOCK_GATING_DEFINES_VH
`define SLAVE_ADDR_W 8'hD2
`define CMD_BLOCK 8'h00
`define COUNT_MIN 8'h01
`define COUNT_MAX 8'h20
`define IDX_CPU 3'h1
`define IDX_BUS 3'h2
`define IDX_F48 3'h3
`define IDX_MED 3'h4
`define IDX_TUNE 3'h5
`define IDX_IDENT 3'h6
`define RST_CPU 8'h07
`define RST_BUS 8'h7F
`define RST_F48 8'hC7
`define RST_MED 8'h3F
`define RST_TUNE 8'h00
`define MASK_CPU 8'h7F
`define MASK_BUS 8'h7F
`define MASK_F48 8'hFF
`define MASK_MED 8'h3F
`define MASK_TUNE 8'h3F
`endif

// *** verification/clock_gating_props.sv ***
// concurrent checks on the gating register block ports
`timescale 1ns/1ps
module clock_gating_props #(
  parameter [3:0] REVISION_CODE = 4'h3,
  parameter [3:0] VENDOR_CODE = 4'h5
) (
  input wire sys_clk,
  input wire resetn,
  input wire scl,
  input wire sda,
  input wire sda_oe,
  input wire current_multiplier_select,
  input wire [7:0] cpu_pair_control,
  input wire [7:0] bus_clock_enables,
  input wire [7:0] fixed48_and_freerun_control,
  input wire [7:0] medium_clock_enables,
  input wire [7:0] delay_edge_tuning,
  input wire [7:0] maker_revision_ident
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // fixed fields and the sampled multiplier bit
  AST_IDENT: assert property ($past(resetn) |->
    maker_revision_ident == {REVISION_CODE, VENDOR_CODE}) else $error("identity byte wrong");
  AST_BUS_RO: assert property (!bus_clock_enables[7]) else $error("bus bit 7 set");
  AST_MED_RO: assert property (medium_clock_enables[7:6] == 2'h0) else $error("med top set");
  AST_TUNE_RO: assert property (delay_edge_tuning[7:6] == 2'h0) else $error("tune top set");
  AST_MULT: assert property ($stable(current_multiplier_select)[*8] |->
    cpu_pair_control[7] == current_multiplier_select) else $error("multiplier bit stale");
  // acknowledge placed in the clock low phase, held at least eight clocks and released within 60
  AST_ACK_LOW: assert property ($rose(sda_oe) |-> !scl) else $error("ack in high phase");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |=> sda_oe[*8]) else $error("ack too short");
  AST_ACK_END: assert property ($rose(sda_oe) |-> ##[1:60] !sda_oe) else $error("ack stuck");
  // control bytes, bar byte1 bit 7, only change while the serial clock is high
  AST_WR_SCL: assert property (!$stable({cpu_pair_control[6:0], bus_clock_enables,
    fixed48_and_freerun_control, medium_clock_enables, delay_edge_tuning}) |-> scl)
    else $error("byte changed off a clock rise");
endmodule

// *** verification/clock_output_gating_regs_tb_top.sv ***
// self-checking bench for the clock output gating control bytes
`timescale 1ns/1ps
`include "clock_gating_defines.vh"
module clock_output_gating_regs_tb_top;
  localparam [3:0] REV = 4'hA; // arbitrary value
  localparam [3:0] VEN = 4'h6; // arbitrary value
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg current_multiplier_select = 1'b0;
  reg [31:0] rnd = 32'h00017512;
  reg [7:0] e [1:5];
  reg [7:0] dv;
  reg ok, a;
  integer n_errors = 0, compares = 0, cycles = 0, i, k;
  wire scl_in, sda_low, sda_oe;
  wire [7:0] cpu, bus, f48, med, tune, ident;
  wire sda_in = ~(sda_oe | sda_low); // pull-up when nobody pulls low
  always #25 sys_clk = ~sys_clk;
  clock_output_gating_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN)) u_clock_output_gating_regs (
    .sys_clk(sys_clk), .resetn(resetn), .scl(scl_in), .sda(sda_in), .sda_oe(sda_oe),
    .current_multiplier_select(current_multiplier_select), .cpu_pair_control(cpu),
    .bus_clock_enables(bus), .fixed48_and_freerun_control(f48), .medium_clock_enables(med),
    .delay_edge_tuning(tune), .maker_revision_ident(ident));
  smbus_host u_smbus_host (.sys_clk(sys_clk), .sda_wire(sda_in), .scl_out(scl_in),
    .sda_low(sda_low));
  function [31:0] nxt(input [31:0] x); begin
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  end endfunction
  task print_verdict; begin
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  task check(input [63:0] nm, input [7:0] seen, input [7:0] exp); begin
    compares = compares + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected %0s expected %h seen %h", nm, exp, seen);
    end
  end endtask
  // all control bytes against the bench copy
  task check_all; begin
    check("cpu", cpu, {current_multiplier_select, e[1][6:0]});
    check("bus", bus, e[2] & `MASK_BUS);
    check("f48", f48, e[3] & `MASK_F48);
    check("med", med, e[4] & `MASK_MED);
    check("tune", tune, e[5] & `MASK_TUNE);
    check("ident", ident, {REV, VEN});
  end endtask
  // one block write with its expected acknowledges
  task xfer(input [7:0] adr, input [7:0] cmd, input [7:0] cnt, input integer n); begin
    rnd = nxt(rnd);
    current_multiplier_select = rnd[9];
    ok = adr == `SLAVE_ADDR_W;
    u_smbus_host.start;
    u_smbus_host.send(adr, a);
    check("ack_adr", {7'h00, a}, {7'h00, ok});
    ok = ok && cmd == `CMD_BLOCK;
    u_smbus_host.send(cmd, a);
    check("ack_cmd", {7'h00, a}, {7'h00, ok});
    ok = ok && cnt >= `COUNT_MIN && cnt <= `COUNT_MAX;
    u_smbus_host.send(cnt, a);
    check("ack_cnt", {7'h00, a}, {7'h00, ok});
    for (k = 0; k < n; k = k + 1) begin
      rnd = nxt(rnd);
      dv = (k == 4) ? (rnd[7:0] | 8'h08) : rnd[7:0];
      u_smbus_host.send(dv, a);
      check("ack_dat", {7'h00, a}, {7'h00, ok && k < cnt});
      if (ok && k < cnt && k >= 1 && k <= 5) e[k] = dv;
    end
    u_smbus_host.stop;
    check_all;
  end endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  // bench copy of the power-up bytes
  task load_defaults; begin
    e[1] = `RST_CPU;
    e[2] = `RST_BUS;
    e[3] = `RST_F48;
    e[4] = `RST_MED;
    e[5] = `RST_TUNE;
  end endtask
  // reset, defaults, random writes, a mid-run reset, then boundary and refused transfers
  initial begin
    load_defaults;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    check_all;
    for (i = 0; i < 3; i = i + 1) xfer(`SLAVE_ADDR_W, `CMD_BLOCK, 8'h06, 6);
    xfer(8'hD2, 8'h00, 8'h09, 9);
    resetn = 1'b0;
    load_defaults;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    check_all;
    xfer(8'hD2, 8'h00, 8'h02, 3);
    xfer(8'hD2, 8'h00, 8'h20, 3);
    xfer(8'hD2, 8'h00, 8'h01, 2);
    xfer(8'hD0, 8'h00, 8'h06, 2);
    xfer(8'hD3, 8'h00, 8'h06, 2);
    xfer(8'hD2, 8'h01, 8'h06, 2);
    xfer(8'hD2, 8'h00, 8'h00, 2);
    xfer(8'hD2, 8'h00, 8'h21, 2);
    print_verdict;
  end
endmodule
bind clock_output_gating_regs clock_gating_props #(.REVISION_CODE(REVISION_CODE),
  .VENDOR_CODE(VENDOR_CODE)) u_clock_gating_props (.sys_clk(sys_clk), .resetn(resetn),
  .scl(scl), .sda(sda), .sda_oe(sda_oe),
  .current_multiplier_select(current_multiplier_select),
  .cpu_pair_control(cpu_pair_control), .bus_clock_enables(bus_clock_enables),
  .fixed48_and_freerun_control(fixed48_and_freerun_control),
  .medium_clock_enables(medium_clock_enables), .delay_edge_tuning(delay_edge_tuning),
  .maker_revision_ident(maker_revision_ident));

// *** verification/smbus_host.sv ***
// smbus host model driving block writes on an open-drain pair
`timescale 1ns/1ps
module smbus_host (
  input wire sys_clk,
  input wire sda_wire,
  output reg scl_out,
  output reg sda_low
);
  integer j;
  reg got;
  // bus idle, both lines released
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  // half period of 12 clocks, above the 10 clock floor
  task hp; begin
    repeat (12) @(negedge sys_clk);
  end endtask
  // one clock pulse, line sampled before the fall
  task pulse; begin
    hp;
    scl_out = 1'b1;
    hp;
    got = ~sda_wire;
    scl_out = 1'b0;
    @(negedge sys_clk);
  end endtask
  // start or repeated start: data falls while clock high
  task start; begin
    sda_low = 1'b0;
    scl_out = 1'b1;
    hp;
    sda_low = 1'b1;
    hp;
    scl_out = 1'b0;
    @(negedge sys_clk);
  end endtask
  // whole byte msb first, then the acknowledge slot
  task send(input [7:0] b, output a); begin
    for (j = 7; j >= 0; j = j - 1) begin
      sda_low = ~b[j];
      pulse;
    end
    sda_low = 1'b0;
    pulse;
    a = got;
  end endtask
  // stop: data rises while clock high
  task stop; begin
    sda_low = 1'b1;
    hp;
    scl_out = 1'b1;
    hp;
    sda_low = 1'b0;
    hp;
  end endtask
endmodule
